// File: hdl/bew_top.sv
// Purpose: event forwarding to chassis manager, payload watchdog, unique id
// Assumes: all inputs come from logic on sys_clk_in
// Notes: every forwarded event uses the extended message
`timescale 1ns/1ps
`include "bew_defines.svh"
module bew_top #(
   parameter int          DEPTH    = 4,
   parameter int          AW       = 2,
   parameter int          TICK_CYC = `BEW_WD_TICK_NS / `BEW_CLK_NS,
   parameter logic [6:0]  GEN_ADDR = 7'h41,
   parameter logic [7:0]  EV_REV   = 8'h04,
   parameter logic [7:0]  WD_STYPE = 8'h23,
   parameter logic [7:0]  WD_SNUM  = 8'h01,
   // arbitrary value, replaced per unit at build time; no system id
   parameter logic [127:0] UID     = 128'h0123456789ABCDEF0011223344556677
) (
   input  wire logic                sys_clk_in,
   input  wire logic                rst_n_in,
   input  wire logic                ce_in,
   input  wire logic [7:0]          addr_in,
   input  wire logic [31:0]         wdata_in,
   input  wire logic                wr_in,
   input  wire logic                rd_in,
   output logic      [31:0]         rdata_out,
   input  wire bew_pkg::bew_event_t ev_in,
   input  wire logic                ev_valid_in,
   output logic                     ev_ready_out,
   input  wire logic [2:0]          op_state_in,
   output bew_pkg::bew_tx_t         tx_out,
   input  wire logic                tx_ready_in,
   input  wire logic                rsp_valid_in,
   input  wire logic [7:0]          rsp_cc_in,
   input  wire logic [7:0]          rsp_ext_in,
   output logic                     payload_reset_out,
   output logic                     power_cycle_out,
   output logic                     power_off_out,
   output logic                     force_deact_out
);
   localparam int EW = $bits(bew_pkg::bew_event_t);

   // byte idx of an outgoing frame; byte 0 is the receiver address
   function automatic logic [7:0] frame_byte(input bew_pkg::bew_event_t ev,
                                             input logic [7:0] tgt,
                                             input logic [6:0] gen,
                                             input logic [3:0] idx);
      logic [7:0] b;
      b = 8'h00;
      unique case (idx)
         4'h0: b = tgt;
         4'h1: b = `BEW_EXT_ID;
         4'h2: b = {ev.sw ? ev.sw_id : gen, ev.sw};
         4'h3: b = {6'h00, ev.sw ? 2'b00 : ev.lun};
         4'h4: b = EV_REV;
         4'h5: b = ev.stype;
         4'h6: b = ev.snum;
         4'h7: b = ev.dirtype;
         4'h8: b = ev.d1;
         4'h9: b = ev.d2;
         4'hA: b = ev.d3;
         default: b = 8'h00;
      endcase
      return b;
   endfunction : frame_byte

   logic [2:0]             ctrl_q;
   logic [7:0]             evr_q;
   logic [15:0]            wd_load_q;
   logic [6:0]             gen_q;
   logic                   wd_restart_q;
   logic                   wd_ev_pend_q;
   bew_pkg::bew_action_t   wd_act_last_q;
   logic [7:0]             rsp_cc_q;
   logic                   rsp_bad_q;
   logic [7:0]             sent_q;
   bew_pkg::bew_tx_state_t st_q;
   bew_pkg::bew_event_t    frame_q;
   logic [7:0]             tgt_q;
   logic [3:0]             idx_q;
   logic [2:0]             op_prev_q;

   wire                    fwd_en  = ctrl_q[0];
   wire bew_pkg::bew_action_t act  = bew_pkg::bew_action_t'(ctrl_q[2:1]);
   wire                    oper    = (op_state_in == `BEW_ST_ACTIVE) ||
                                     (op_state_in == `BEW_ST_DEACT_REQ);
   wire                    wr_ctrl = ce_in && wr_in && addr_in == `BEW_OFF_CTRL;
   wire                    wr_evr  = ce_in && wr_in && addr_in == `BEW_OFF_EVR;
   wire                    wr_load = ce_in && wr_in && addr_in == `BEW_OFF_WD_LOAD;
   wire                    wr_cmd  = ce_in && wr_in && addr_in == `BEW_OFF_WD_CMD;
   wire                    wr_gen  = ce_in && wr_in && addr_in == `BEW_OFF_GEN;

   logic                   wd_run;
   logic [15:0]            wd_cnt;
   logic                   wd_exp;
   logic [EW-1:0]          q_rdata;
   logic [AW:0]            q_level;

   wire bew_pkg::bew_event_t q_head = bew_pkg::bew_event_t'(q_rdata);
   wire                    q_full  = (q_level == (AW+1)'(DEPTH));
   wire                    ext_push = ev_valid_in && ev_ready_out;
   wire                    wd_push  = wd_ev_pend_q && !ext_push && !q_full;
   wire                    q_push   = ce_in && (ext_push || wd_push);
   // logging state plays no part in whether an event leaves
   wire                    start    = (st_q == bew_pkg::BEW_IDLE) && fwd_en &&
                                      (q_level != '0);
   wire                    q_pop    = ce_in && start;
   wire                    tx_take  = tx_out.valid && tx_ready_in;
   wire [AW:0]             lvl_nx   = q_level + (AW+1)'(q_push) - (AW+1)'(q_pop);

   wire bew_pkg::bew_event_t wd_ev = '{sw: 1'b0, sw_id: 7'h00, lun: 2'b00,
                                       stype: WD_STYPE, snum: WD_SNUM,
                                       dirtype: `BEW_WD_DIRTYPE,
                                       d1: {6'h00, wd_act_last_q},
                                       d2: 8'hFF, d3: 8'hFF};
   wire [EW-1:0]           q_wdata  = ext_push ? EW'(ev_in) : EW'(wd_ev);

   wire [31:0] rd_mux =
      (addr_in == `BEW_OFF_CTRL)      ? {29'h0, ctrl_q} :
      (addr_in == `BEW_OFF_EVR)       ? {24'h0, evr_q} :
      (addr_in == `BEW_OFF_WD_LOAD)   ? {16'h0, wd_load_q} :
      (addr_in == `BEW_OFF_WD_CMD)    ? {16'h0, wd_cnt} :
      (addr_in == `BEW_OFF_WD_STAT)   ? {27'h0, wd_ev_pend_q, wd_act_last_q, oper,
                                         wd_run} :
      (addr_in == `BEW_OFF_GEN)       ? {25'h0, gen_q} :
      (addr_in == `BEW_OFF_EV_STAT)   ? {7'h0, rsp_bad_q, sent_q, rsp_cc_q,
                                         5'h0, 3'(q_level)} :
      (addr_in == `BEW_OFF_UID0)      ? UID[31:0] :
      (addr_in == `BEW_OFF_UID0 + 8'h04) ? UID[63:32] :
      (addr_in == `BEW_OFF_UID0 + 8'h08) ? UID[95:64] :
      (addr_in == `BEW_OFF_UID0 + 8'h0C) ? UID[127:96] : 32'h0000_0000;

   bew_evq #(.W(EW), .DEPTH(DEPTH), .AW(AW)) u_q (
      .clk_in    (sys_clk_in),
      .rst_n_in  (rst_n_in),
      .ce_in     (ce_in),
      .push_in   (q_push),
      .wdata_in  (q_wdata),
      .pop_in    (q_pop),
      .rdata_out (q_rdata),
      .level_out (q_level)
   );

   bew_wdt #(.TICK_CYC(TICK_CYC), .CW(16)) u_wdt (
      .clk_in     (sys_clk_in),
      .rst_n_in   (rst_n_in),
      .ce_in      (ce_in),
      .oper_in    (oper),
      .restart_in (wd_restart_q),
      .load_in    (wd_load_q),
      .run_out    (wd_run),
      .cnt_out    (wd_cnt),
      .expire_out (wd_exp)
   );

   // register port: get/set/reset watchdog live here
   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         ctrl_q       <= `BEW_CTRL_RST;   // forwarding on by default
         evr_q        <= `BEW_EVR_RST;
         wd_load_q    <= `BEW_WD_LOAD_RST;
         gen_q        <= 7'h00;
         wd_restart_q <= 1'b0;
         rdata_out    <= 32'h0000_0000;
         op_prev_q    <= 3'h0;
      end
      else if (ce_in)
      begin
         if (wr_ctrl)
            ctrl_q <= wdata_in[2:0];
         if (wr_evr)
            evr_q <= wdata_in[7:0];
         if (wr_load)
            wd_load_q <= wdata_in[15:0];
         gen_q        <= wr_gen ? wdata_in[6:0] : (op_prev_q == 3'h0 ? GEN_ADDR : gen_q);
         wd_restart_q <= wr_cmd;
         rdata_out    <= rd_in ? rd_mux : 32'h0000_0000;
         op_prev_q    <= 3'h7;
      end
   end

   // watchdog expiry actions and sensor event
   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         payload_reset_out <= 1'b0;
         power_cycle_out   <= 1'b0;
         power_off_out     <= 1'b0;
         force_deact_out   <= 1'b0;
         wd_ev_pend_q      <= 1'b0;
         wd_act_last_q     <= bew_pkg::BEW_ACT_NONE;
      end
      else if (ce_in)
      begin
         payload_reset_out <= wd_exp && act == bew_pkg::BEW_ACT_HARD_RESET;
         power_cycle_out   <= wd_exp && act == bew_pkg::BEW_ACT_POWER_CYCLE;
         force_deact_out   <= wd_exp && act == bew_pkg::BEW_ACT_POWER_DOWN;
         // power stays off until op_state_in falls below the active state
         if (wd_exp && act == bew_pkg::BEW_ACT_POWER_DOWN)
            power_off_out <= 1'b1;
         else if (op_state_in < `BEW_ST_ACTIVE)
            power_off_out <= 1'b0;
         if (wd_exp && act != bew_pkg::BEW_ACT_NONE)
         begin
            wd_ev_pend_q  <= 1'b1;       // set wins over the drain
            wd_act_last_q <= act;
         end
         else if (wd_push)
            wd_ev_pend_q <= 1'b0;
      end
   end

   // sender: one frame at a time, oldest first
   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         st_q         <= bew_pkg::BEW_IDLE;
         tx_out       <= '0;
         frame_q      <= '0;
         tgt_q        <= 8'h00;
         idx_q        <= 4'h0;
         ev_ready_out <= 1'b0;
         rsp_cc_q     <= 8'h00;
         rsp_bad_q    <= 1'b0;
         sent_q       <= 8'h00;
      end
      else if (ce_in)
      begin
         ev_ready_out <= (lvl_nx != (AW+1)'(DEPTH));
         unique case (st_q)
            bew_pkg::BEW_IDLE:
               if (start)
               begin
                  frame_q <= q_head;
                  tgt_q   <= evr_q;      // receiver as it stands now
                  idx_q   <= 4'h0;
                  tx_out  <= '{valid: 1'b1, last: 1'b0,
                               data: frame_byte(q_head, evr_q, gen_q, 4'h0)};
                  st_q    <= bew_pkg::BEW_SEND;
               end
            bew_pkg::BEW_SEND:
               if (tx_take)
               begin
                  if (tx_out.last)
                  begin
                     tx_out <= '0;
                     st_q   <= bew_pkg::BEW_WAIT;
                  end
                  else
                  begin
                     idx_q  <= idx_q + 4'h1;
                     tx_out <= '{valid: 1'b1,
                                 last: (idx_q + 4'h1) == `BEW_FRAME_LAST,
                                 data: frame_byte(frame_q, tgt_q, gen_q, idx_q + 4'h1)};
                  end
               end
            bew_pkg::BEW_WAIT:
               if (rsp_valid_in)
               begin
                  rsp_cc_q  <= rsp_cc_in;
                  rsp_bad_q <= (rsp_ext_in != `BEW_EXT_ID);
                  sent_q    <= sent_q + 8'h01;
                  st_q      <= bew_pkg::BEW_IDLE;
               end
            default:
               st_q <= bew_pkg::BEW_IDLE;
         endcase
      end
   end

   property p_evr_init;
      @(posedge sys_clk_in) $rose(rst_n_in) |-> evr_q == `BEW_EVR_RST;
   endproperty
   a_evr_init: assert property (p_evr_init) else $error("receiver not 20h");
   property p_ext_id;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
         tx_out.valid && idx_q == 4'h1 |-> tx_out.data == `BEW_EXT_ID;
   endproperty
   a_ext_id: assert property (p_ext_id) else $error("bad extension id");
   property p_gen1;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
         tx_out.valid && idx_q == 4'h2 |-> tx_out.data[0] == frame_q.sw &&
            (frame_q.sw || tx_out.data[7:1] == gen_q);
   endproperty
   a_gen1: assert property (p_gen1) else $error("generator byte 1 wrong");
   property p_gen2;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
         tx_out.valid && idx_q == 4'h3 |-> tx_out.data[7:2] == 6'h00 &&
            (!frame_q.sw || tx_out.data[1:0] == 2'b00);
   endproperty
   a_gen2: assert property (p_gen2) else $error("generator byte 2 wrong");
   property p_target;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
         ce_in && start |=> tx_out.valid && tx_out.data == $past(evr_q) ##0
            (tx_out.data == tgt_q);
   endproperty
   a_target: assert property (p_target) else $error("frame not to receiver");
   property p_inert;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
         ce_in && !oper |=> !wd_run && !wd_exp ##1 !wd_exp;
   endproperty
   a_inert: assert property (p_inert) else $error("watchdog ran off-state");
   property p_leave;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
         // counter shows the load value one edge after each enabled cycle outside the active states with no load write
         rst_n_in && ce_in && !oper && !wr_load |=> wd_cnt == wd_load_q;
   endproperty
   a_leave: assert property (p_leave) else $error("watchdog not reset");
   property p_hard;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
         ce_in && wd_exp && act == bew_pkg::BEW_ACT_HARD_RESET |=>
            payload_reset_out && !force_deact_out && !power_cycle_out;
   endproperty
   a_hard: assert property (p_hard) else $error("hard reset action wrong");
   property p_cycle;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
         ce_in && wd_exp && act == bew_pkg::BEW_ACT_POWER_CYCLE |=>
            power_cycle_out && !force_deact_out;
   endproperty
   a_cycle: assert property (p_cycle) else $error("power cycle action wrong");
   property p_down;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
         ce_in && wd_exp && act == bew_pkg::BEW_ACT_POWER_DOWN |=>
            power_off_out && force_deact_out;
   endproperty
   a_down: assert property (p_down) else $error("power down action wrong");
   property p_wd_ev;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
         ce_in && wd_exp && act != bew_pkg::BEW_ACT_NONE |=> wd_ev_pend_q;
   endproperty
   a_wd_ev: assert property (p_wd_ev) else $error("no watchdog event");
   property p_fwd;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
         st_q == bew_pkg::BEW_IDLE && fwd_en && q_level != '0 && ce_in
            |=> st_q == bew_pkg::BEW_SEND;
   endproperty
   a_fwd: assert property (p_fwd) else $error("queued event not sent");

   c_frame: cover property (@(posedge sys_clk_in) tx_take && tx_out.last);
   c_sw_ev: cover property (@(posedge sys_clk_in) start && q_head.sw);
   c_expire: cover property (@(posedge sys_clk_in) wd_exp);
   c_full: cover property (@(posedge sys_clk_in) q_full);
endmodule : bew_top

// File: hdl/bew_defines.svh
// Purpose: constants for the blade event forward and watchdog block
// Assumes: 100 MHz sys_clk_in, 32-bit register port
// Notes: offsets are byte addresses
// Contract
// - forward every sensor event to chassis manager
// - forwarding ignores local event log condition
// - set-receiver write retargets all later events
// - receiver address is 20h after reset
// - payload software events use extended message
// - extension identifier 02h in request and response
// - generator byte: address[7:1], type bit 0
// - second generator byte: reserved, lun or zero
// - bytes 4-10 follow standard event layout
// - get, set, reset watchdog commands supported
// - watchdog sensor asserts event per action
// - watchdog counts only in active states
// - leaving active states resets the watchdog
// - hard reset action resets payload only
// - power cycle action cycles payload only
// - power down forces deactivation in progress
// - pre-timeout actions optional, not provided
// - device unique identifier readable
// - system unique identifier optional, not provided
`ifndef BEW_DEFINES_SVH
`define BEW_DEFINES_SVH
`define BEW_OFF_CTRL     8'h00
`define BEW_OFF_EVR      8'h04
`define BEW_OFF_WD_LOAD  8'h08
`define BEW_OFF_WD_CMD   8'h0C
`define BEW_OFF_WD_STAT  8'h10
`define BEW_OFF_GEN      8'h14
`define BEW_OFF_EV_STAT  8'h18
`define BEW_OFF_UID0     8'h20
`define BEW_CTRL_RST     3'h1
`define BEW_EVR_RST      8'h20
`define BEW_EXT_ID       8'h02
`define BEW_WD_LOAD_RST  16'h000A
`define BEW_WD_DIRTYPE   8'h6F
`define BEW_ST_ACTIVE    3'h4
`define BEW_ST_DEACT_REQ 3'h5
`define BEW_ST_DEACT_PRG 3'h6
`define BEW_CLK_NS       10
`define BEW_WD_TICK_NS   100000000
`define BEW_FRAME_LAST   4'hA
`endif

// File: hdl/bew_pkg.sv
// Purpose: types for the blade event forward and watchdog block
// Assumes: nothing
// Notes: event fields are raw; framing happens at send time
package bew_pkg;
   typedef struct packed {
      logic       sw;
      logic [6:0] sw_id;
      logic [1:0] lun;
      logic [7:0] stype;
      logic [7:0] snum;
      logic [7:0] dirtype;
      logic [7:0] d1;
      logic [7:0] d2;
      logic [7:0] d3;
   } bew_event_t;
   typedef struct packed {
      logic       valid;
      logic       last;
      logic [7:0] data;
   } bew_tx_t;
   typedef enum logic [1:0] {
      BEW_ACT_NONE = 2'b00, BEW_ACT_HARD_RESET = 2'b01,
      BEW_ACT_POWER_DOWN = 2'b10, BEW_ACT_POWER_CYCLE = 2'b11
   } bew_action_t;
   typedef enum logic [1:0] {
      BEW_IDLE = 2'b00, BEW_SEND = 2'b01, BEW_WAIT = 2'b10
   } bew_tx_state_t;
endpackage : bew_pkg

// File: hdl/bew_evq.sv
// Purpose: in-order event queue in flip-flops
// Assumes: caller never pushes when full nor pops when empty
// Notes: rdata shows the oldest entry
`timescale 1ns/1ps
module bew_evq #(
   parameter int W     = 58,
   parameter int DEPTH = 4,
   parameter int AW    = 2
) (
   input  wire logic          clk_in,
   input  wire logic          rst_n_in,
   input  wire logic          ce_in,
   input  wire logic          push_in,
   input  wire logic [W-1:0]  wdata_in,
   input  wire logic          pop_in,
   output logic      [W-1:0]  rdata_out,
   output logic      [AW:0]   level_out
);
   logic [W-1:0]  mem_q [DEPTH];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   assign rdata_out = mem_q[rp_q];
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         wp_q      <= '0;
         rp_q      <= '0;
         level_out <= '0;
      end
      else if (ce_in)
      begin
         if (push_in)
            wp_q <= wp_q + 1'b1;
         if (pop_in)
            rp_q <= rp_q + 1'b1;
         level_out <= level_out + (AW+1)'(push_in) - (AW+1)'(pop_in);
      end
   end
   always_ff @(posedge clk_in)
   begin
      if (ce_in && push_in)
         mem_q[wp_q] <= wdata_in;
   end
endmodule : bew_evq

// File: hdl/bew_wdt.sv
// Purpose: payload watchdog countdown
// Assumes: oper_in is high only in the two active states
// Notes: expire_out is a one-cycle pulse
`timescale 1ns/1ps
module bew_wdt #(
   parameter int TICK_CYC = 10000000,
   parameter int CW       = 16
) (
   input  wire logic          clk_in,
   input  wire logic          rst_n_in,
   input  wire logic          ce_in,
   input  wire logic          oper_in,
   input  wire logic          restart_in,
   input  wire logic [CW-1:0] load_in,
   output logic               run_out,
   output logic      [CW-1:0] cnt_out,
   output logic               expire_out
);
   localparam int PW = $clog2(TICK_CYC + 1);
   logic [PW-1:0] presc_q;
   wire           tick = (presc_q == PW'(TICK_CYC - 1));
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         run_out    <= 1'b0;
         cnt_out    <= '0;
         expire_out <= 1'b0;
         presc_q    <= '0;
      end
      else if (ce_in)
      begin
         expire_out <= 1'b0;
         presc_q    <= tick ? '0 : presc_q + 1'b1;
         if (!oper_in)
         begin
            // inert and held in reset outside active states
            run_out <= 1'b0;
            cnt_out <= load_in;
            presc_q <= '0;
         end
         else if (restart_in)
         begin
            run_out <= 1'b1;
            cnt_out <= load_in;
            presc_q <= '0;
         end
         else if (run_out && tick)
         begin
            if (cnt_out <= CW'(1))
            begin
               run_out    <= 1'b0; // acts once, then waits for restart
               cnt_out    <= '0;
               expire_out <= 1'b1; // no pre-timeout stage
            end
            else
               cnt_out <= cnt_out - 1'b1;
         end
      end
   end
endmodule : bew_wdt

// File: tb/bew_cm_model.sv
// Purpose: chassis manager model that takes forwarded event frames
// Assumes: one frame outstanding at a time
// Notes: slow_in makes it take a byte only every other cycle
`timescale 1ns/1ps
module bew_cm_model (
   input  wire logic             clk_in,
   input  wire logic             rst_n_in,
   input  wire bew_pkg::bew_tx_t tx_in,
   input  wire logic             slow_in,
   output logic                  tx_ready_out,
   output logic                  rsp_valid_out,
   output logic      [7:0]       rsp_cc_out,
   output logic      [7:0]       rsp_ext_out,
   output logic      [87:0]      frame_out,
   output logic      [7:0]       frames_out
);
   logic [87:0] acc_q;
   logic        take;
   logic        fin;
   assign take = tx_in.valid && tx_ready_out;
   assign fin  = take && tx_in.last;
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         tx_ready_out  <= 1'h0;
         rsp_valid_out <= 1'h0;
         rsp_cc_out    <= 8'hFF;
         rsp_ext_out   <= 8'hFD;
         acc_q         <= 88'h0;
         frame_out     <= 88'h0;
         frames_out    <= 8'h00;
      end
      else
      begin
         tx_ready_out  <= slow_in ? ~tx_ready_out : 1'h1;
         acc_q         <= take ? {acc_q[79:0], tx_in.data} : acc_q;
         // extended message accepted like any other
         rsp_valid_out <= fin;
         // idle response lines show the inverse, not a stale good value
         rsp_cc_out    <= fin ? 8'h00 : 8'hFF;
         rsp_ext_out   <= fin ? 8'h02 : 8'hFD;
         frame_out     <= fin ? {acc_q[79:0], tx_in.data} : frame_out;
         frames_out    <= frames_out + {7'h00, fin};
      end
   end
endmodule : bew_cm_model

// File: tb/tb_bew_top.sv
// Purpose: self-checking bench for the event forward and watchdog block
// Assumes: watchdog tick shortened to 4 cycles
// Notes: ordinary events come from a row table
`timescale 1ns/1ps
module tb_bew_top;
   typedef struct packed {
      bew_pkg::bew_event_t ev;
      logic [7:0]          g1;
      logic [7:0]          g2;
   } bew_row_t;
   // arbitrary value
   localparam logic [127:0] UIDV = 128'hA5A5000011112222333344445555C3C3;
   bew_row_t            rows [3] = '{
      {1'h0, 7'h7F, 2'h2, 8'h01, 8'h10, 8'h01, 8'h57, 8'hA5, 8'h3C, 8'h82, 8'h02},
      {1'h1, 7'h35, 2'h3, 8'h12, 8'h21, 8'h6F, 8'h01, 8'hFF, 8'hFF, 8'h6B, 8'h00},
      {1'h0, 7'h00, 2'h1, 8'h04, 8'h07, 8'h81, 8'h00, 8'h11, 8'h22, 8'h82, 8'h01}};
   logic [7:0]          exp_w [4] = '{8'h00, 8'h11, 8'hC1, 8'h21};
   logic                clk = 1'h0, rst_n = 1'h0, wr = 1'h0, rd = 1'h0, evv = 1'h0;
   logic                slow = 1'h1, ce = 1'h1, evr, txr, rv, prst, pcyc, poff, fdeact;
   logic [7:0]          addr = 8'h00, rcc, rext, nfr;
   logic [31:0]         wdata = 32'h0, rdata;
   logic [2:0]          st = 3'h0;
   logic [87:0]         frame;
   bew_pkg::bew_event_t ev = '0;
   bew_pkg::bew_tx_t    tx;
   int                  err_total = 0, compares = 0;
   always #5 clk = ~clk;
   bew_top #(.TICK_CYC(4), .UID(UIDV)) bew_top_inst (.sys_clk_in(clk), .rst_n_in(rst_n),
      .ce_in(ce), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
      .rdata_out(rdata), .ev_in(ev), .ev_valid_in(evv), .ev_ready_out(evr),
      .op_state_in(st), .tx_out(tx), .tx_ready_in(txr), .rsp_valid_in(rv),
      .rsp_cc_in(rcc), .rsp_ext_in(rext), .payload_reset_out(prst),
      .power_cycle_out(pcyc), .power_off_out(poff), .force_deact_out(fdeact));
   bew_cm_model bew_cm_model_inst (.clk_in(clk), .rst_n_in(rst_n), .tx_in(tx),
      .slow_in(slow), .tx_ready_out(txr), .rsp_valid_out(rv), .rsp_cc_out(rcc),
      .rsp_ext_out(rext), .frame_out(frame), .frames_out(nfr));
   task automatic wrap_up;
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up
   task automatic check(input logic [87:0] got, input logic [87:0] exp, input string m);
      compares++;
      if (got !== exp)
      begin
         err_total++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask : check
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'h1;
      @(posedge clk);
      wr    <= 1'h0;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'h1;
      @(posedge clk);
      rd   <= 1'h0;
      #1 d = rdata;
   endtask : rd_reg
   task automatic push(input bew_pkg::bew_event_t e);
      @(posedge clk);
      ev  <= e;
      evv <= 1'h1;
      // ready is judged as it stands before the taking edge
      #1;
      while (evr !== 1'h1)
      begin
         @(posedge clk);
         #1;
      end
      @(posedge clk);
      evv <= 1'h0;
   endtask : push
   task automatic wait_frame;
      logic [7:0] n0;
      n0 = nfr;
      for (int i = 0; i < 300 && nfr === n0; i++) @(posedge clk);
      #1;
      if (nfr === n0)
      begin
         err_total++;
         $display("mismatch at %0t: no frame", $time);
      end
   endtask : wait_frame
   // which of power off and the three action strobes went high, then pulse count of the three strobes
   task automatic watch(output logic [7:0] w);
      logic [3:0] seen;
      logic [3:0] n;
      seen = 4'h0;
      n    = 4'h0;
      repeat (200)
      begin
         @(posedge clk);
         #1 seen = seen | {poff, fdeact, pcyc, prst};
         n = n + {3'h0, fdeact | pcyc | prst};
      end
      w = {seen, n};
   endtask : watch
   initial
   begin
      logic [31:0] d;
      logic [7:0]  w;
      repeat (8) @(posedge clk);
      rst_n <= 1'h1;
      rd_reg(8'h04, d);
      check(d, 32'h20, "receiver after reset");
      check(evr, 1'h1, "ready after reset");
      rd_reg(8'h30, d);
      check(d, 32'h0, "unmapped read");
      rd_reg(8'h20, d);
      check(d, UIDV[31:0], "id word 0");
      rd_reg(8'h2C, d);
      check(d, UIDV[127:96], "id word 3");
      foreach (rows[i]) push(rows[i].ev);
      foreach (rows[i])
      begin
         wait_frame();
         check(frame, {8'h20, 8'h02, rows[i].g1, rows[i].g2, 8'h04, rows[i].ev[47:0]},
               "event frame");
      end
      rd_reg(8'h18, d);
      check(d, 32'h0003_0000, "response status");
      slow <= 1'h0;
      wr_reg(8'h04, 32'h82);
      wr_reg(8'h08, 32'h3);
      for (int a = 0; a < 4; a++)
      begin
         wr_reg(8'h00, {29'h0, ((a == 0) ? 2'h1 : a[1:0]), 1'h1});
         st <= (a == 0) ? 3'h3 : (a == 2) ? 3'h5 : 3'h4;
         wr_reg(8'h0C, 32'h0);
         watch(w);
         check(w, exp_w[a], "expiry action");
         if (a > 0)
            check({frame[87:72], frame[47:40], frame[31:16]},
                  {24'h820223, 8'h6F, 6'h0, a[1:0]}, "watchdog frame");
         st <= 3'h0;
      end
      ce <= 1'h0;
      wr_reg(8'h04, 32'h55);
      ce <= 1'h1;
      rd_reg(8'h04, d);
      check(d, 32'h82, "write while frozen");
      wr_reg(8'h00, 32'h0);
      repeat (4) push(rows[0].ev);
      #1 check(evr, 1'h0, "full queue refuses");
      rd_reg(8'h18, d);
      check(d, 32'h0006_0004, "frames done and level");
      @(posedge clk);
      rst_n <= 1'h0;
      repeat (2) @(posedge clk);
      rst_n <= 1'h1;
      rd_reg(8'h04, d);
      check(d, 32'h20, "receiver after second reset");
      rd_reg(8'h18, d);
      check(d, 32'h0, "status after second reset");
      wrap_up();
   end
   initial
   begin
      #50000;
      err_total++;
      wrap_up();
   end
endmodule : tb_bew_top
